// *** rtl/smbus_master_slave_control.sv ***
`timescale 1ns/1ns
`include "smbus_defines.svh"

// ----------------------------------------------------------------------------
// received byte buffer
// ----------------------------------------------------------------------------
module rx_fifo #(
    parameter int WIDTH = `FIFO_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
        logic ov;
        logic [WIDTH-1:0] od;
    } fifo_t;

    fifo_t q;
    fifo_t n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] used;
    logic push;

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("rx_fifo depth must be a power of two of at least 2");
    end

    assign used = q.wptr - q.rptr;
    assign in_ready = used != (AW+1)'(DEPTH);
    assign push = in_valid & in_ready;
    assign out_valid = q.ov;
    assign out_data = q.od;

    always_comb begin
        n = q;
        if (push) begin
            n.wptr = q.wptr + 1'b1;
        end
        // output stage is a register so the consumer sees a clean flop
        if ((!q.ov || out_ready) && used != '0) begin
            n.od = mem[q.rptr[AW-1:0]];
            n.ov = 1'b1;
            n.rptr = q.rptr + 1'b1;
        end else if (out_ready) begin
            n.ov = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[q.wptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// ----------------------------------------------------------------------------
// control, configuration and bit engine
// ----------------------------------------------------------------------------
module smbus_master_slave_control (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic t0_ovf,
    input wire logic t1_ovf,
    input wire logic t2h_ovf,
    input wire logic t2l_ovf,
    input wire logic timer3_split_mode,
    output logic t3_reload_lo,
    output logic t3_reload_hi,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready
);
    import smbus_pkg::*;

    smbus_pkg::ctl_t q;
    smbus_pkg::ctl_t n;
    logic ovf;
    logic scl_h;
    logic scl_p;
    logic sda_h;
    logic sda_p;
    logic start_ev;
    logic stop_ev;
    logic rise;
    logic fall;
    logic active;
    logic stall;
    logic boundary;
    logic want;
    logic fifo_in_ready;

    always_comb begin
        unique case (q.cs)
            2'h0: ovf = t0_ovf;
            2'h1: ovf = t1_ovf;
            2'h2: ovf = t2h_ovf;
            2'h3: ovf = t2l_ovf;
        endcase
    end

    // only second and third sync stages are looked at
    assign scl_h = q.scl_s[1];
    assign scl_p = q.scl_s[2];
    assign sda_h = q.sda_s[1];
    assign sda_p = q.sda_s[2];
    assign start_ev = scl_h & scl_p & sda_p & ~sda_h;
    assign stop_ev = scl_h & scl_p & ~sda_p & sda_h;
    assign rise = scl_h & ~scl_p;
    assign fall = ~scl_h & scl_p;
    assign active = q.master | q.slv;
    // stall while event pending or buffer full
    assign stall = q.si | q.rx_push;
    assign boundary = q.bitcnt == 4'h0 && q.framed;

    always_comb begin
        n = q;
        want = 1'b0;
        n.scl_s = {q.scl_s[1:0], scl_in};
        n.sda_s = {q.sda_s[1:0], sda_in};
        if (q.rx_push && fifo_in_ready) begin
            n.rx_push = 1'b0;
        end
        if (ovf && q.ovf_cnt != 2'h3) begin
            n.ovf_cnt = q.ovf_cnt + 2'h1;
        end
        if (q.hold_cnt != 4'h0) begin
            n.hold_cnt = q.hold_cnt - 4'h1;
        end
        if (q.setup_cnt != 4'h0) begin
            n.setup_cnt = q.setup_cnt - 4'h1;
        end

        // ------------------------------------------------------------------
        // register writes; hardware sets below override clears here
        // ------------------------------------------------------------------
        if (sfr_wr) begin
            if (sfr_addr == `CFG_ADDR) begin
                n.on = sfr_wdata[`CFG_ON];
                n.slave_silence = sfr_wdata[`CFG_INH];
                n.lsh = sfr_wdata[`CFG_LSH];
                n.toe = sfr_wdata[`CFG_TOE];
                n.fte = sfr_wdata[`CFG_FTE];
                n.cs = sfr_wdata[`CFG_CS_HI:`CFG_CS_LO];
            end else if (sfr_addr == `CTRL_ADDR) begin
                n.begin_condition_flag = sfr_wdata[`CTRL_STA];
                n.halt_condition_flag = sfr_wdata[`CTRL_STO];
                // written ack is the level to send
                n.ack = sfr_wdata[`CTRL_ACK];
                if (!sfr_wdata[`CTRL_SI]) begin
                    n.si = 1'b0;
                    n.arbitration_lost_flag = 1'b0;
                end
            end else if (sfr_addr == `DATA_ADDR) begin
                n.dat = sfr_wdata;
                n.dat_wr = 1'b1;
            end
        end
        if (sfr_rd) begin
            if (sfr_addr == `CTRL_ADDR) begin
                n.rdata = {q.master, q.transmitter_flag, q.begin_condition_flag, q.halt_condition_flag,
                           q.response_needed, q.arbitration_lost_flag, q.ack, q.si};
            end else if (sfr_addr == `CFG_ADDR) begin
                n.rdata = {q.on, q.slave_silence, q.busy, q.lsh, q.toe, q.fte, q.cs};
            end else if (sfr_addr == `DATA_ADDR) begin
                n.rdata = q.dat;
            end else begin
                n.rdata = 8'h00;
            end
        end

        // timer 3 held in reload while clock high
        n.t3_rl_hi = q.toe & scl_h;
        // split mode leaves low byte free
        n.t3_rl_lo = q.toe & scl_h & ~timer3_split_mode;

        if (q.on) begin
            // ---------------------------------------------------------------
            // free timeout
            // ---------------------------------------------------------------
            // both lines high over ten periods
            if (q.fte && scl_h && sda_h) begin
                if (ovf && q.free_cnt != 4'hF) begin
                    n.free_cnt = q.free_cnt + 4'h1;
                end
                if (ovf && q.free_cnt == `FREE_PERIODS && q.busy) begin
                    n.busy = 1'b0;
                    n.halt_condition_flag = 1'b1;
                    n.si = 1'b1;
                    n.slv = 1'b0;
                end
            end else begin
                n.free_cnt = 4'h0;
            end

            // ---------------------------------------------------------------
            // conditions seen on the bus
            // ---------------------------------------------------------------
            if (start_ev) begin
                n.busy = 1'b1;
                // start's own clock fall must not count as a data bit
                n.bitcnt = 4'hF;
                if (!q.master && q.st != ST_START) begin
                    n.slv = 1'b1;
                    n.addr_ph = 1'b1;
                    n.transmitter_flag = 1'b0;
                    n.framed = 1'b0;
                    // mute lifts at the next start
                    n.ignore = 1'b0;
                    n.inh_eff = q.slave_silence;
                end
            end
            if (stop_ev) begin
                n.busy = 1'b0;
                n.slv = 1'b0;
                if (q.slv && !q.addr_ph && !q.inh_eff) begin
                    n.halt_condition_flag = 1'b1;
                    n.si = 1'b1;
                end
                if (q.master && q.st != ST_STOP) begin
                    n.arbitration_lost_flag = 1'b1;
                    n.halt_condition_flag = 1'b1;
                    n.si = 1'b1;
                    n.master = 1'b0;
                    n.st = ST_IDLE;
                end
            end

            // ---------------------------------------------------------------
            // bit shifting on clock edges
            // ---------------------------------------------------------------
            if (active && boundary) begin
                n.transmitter_flag = q.dat_wr;
            end
            if (active && rise) begin
                if (q.bitcnt == 4'h0) begin
                    n.dat_wr = 1'b0;
                end
                if (q.bitcnt != `ACK_SLOT) begin
                    // msb first, first bit ends at top
                    n.dat = {q.dat[6:0], sda_h};
                    if (q.transmitter_flag && q.dat[7] && !sda_h) begin
                        n.arbitration_lost_flag = 1'b1;
                        n.si = 1'b1;
                        n.master = 1'b0;
                        n.transmitter_flag = 1'b0;
                        n.slv = 1'b1;
                        n.st = ST_IDLE;
                    end
                end else if (q.transmitter_flag) begin
                    n.ack = ~sda_h;
                end
            end
            if (active && fall) begin
                // hold time before data may change
                n.hold_cnt = q.lsh ? `HOLD_EXT : `HOLD_NORM;
                if (q.bitcnt == `LAST_BIT) begin
                    n.bitcnt = `ACK_SLOT;
                    if (!q.transmitter_flag) begin
                        n.response_needed = 1'b1;
                        n.ack = 1'b0;
                        n.rx_byte = q.dat;
                        n.rx_push = 1'b1;
                        if (q.addr_ph) begin
                            n.begin_condition_flag = 1'b1;
                        end
                        if (q.master || !q.inh_eff) begin
                            n.si = 1'b1;
                        end
                    end
                end else if (q.bitcnt == `ACK_SLOT) begin
                    n.bitcnt = 4'h0;
                    n.response_needed = 1'b0;
                    n.framed = 1'b1;
                    n.addr_ph = 1'b0;
                    if (q.transmitter_flag && (q.master || !q.inh_eff)) begin
                        n.si = 1'b1;
                    end
                    if (q.slv && q.addr_ph && (!q.ack || q.inh_eff)) begin
                        n.slv = 1'b0;
                        n.ignore = 1'b1;
                    end
                end else if (q.bitcnt == 4'hF) begin
                    n.bitcnt = 4'h0;
                end else begin
                    n.bitcnt = q.bitcnt + 4'h1;
                end
            end
            // slave holds clock low while stalled
            if (q.slv) begin
                n.scl_lo = stall & ~scl_h;
            end

            // ---------------------------------------------------------------
            // master sequencing
            // ---------------------------------------------------------------
            unique case (q.st)
                ST_IDLE: begin
                    if (q.begin_condition_flag && !q.busy && !q.master) begin
                        n.st = ST_START;
                        n.ovf_cnt = 2'h0;
                    end
                end
                ST_START: begin
                    if (q.sda_lo && q.ovf_cnt != 2'h0) begin
                        n.scl_lo = 1'b1;
                        n.st = ST_LOW;
                        n.master = 1'b1;
                        n.transmitter_flag = 1'b1;
                        n.slv = 1'b0;
                        n.si = 1'b1;
                        n.busy = 1'b1;
                        n.bitcnt = 4'hF;
                        n.framed = 1'b0;
                        n.ovf_cnt = 2'h0;
                    end
                end
                ST_LOW: begin
                    n.scl_lo = 1'b1;
                    if (!stall) begin
                        if (boundary && q.halt_condition_flag) begin
                            n.st = ST_STOP;
                        end else if (boundary && q.begin_condition_flag) begin
                            n.st = ST_RSTART;
                        end else if (q.ovf_cnt != 2'h0 && q.hold_cnt == 4'h0
                                     && q.setup_cnt == 4'h0) begin
                            n.scl_lo = 1'b0;
                            n.st = ST_HIGH;
                            n.ovf_cnt = 2'h0;
                        end
                    end
                end
                ST_HIGH: begin
                    // stretched clock restarts the high count
                    if (!scl_h) begin
                        n.ovf_cnt = 2'h0;
                    end else if (q.ovf_cnt == `HIGH_OVF) begin
                        n.scl_lo = 1'b1;
                        n.st = ST_LOW;
                        n.ovf_cnt = 2'h0;
                    end
                end
                ST_STOP: begin
                    if (!q.sda_lo || q.setup_cnt != 4'h0) begin
                        n.scl_lo = 1'b1;
                        n.ovf_cnt = 2'h0;
                    end else begin
                        n.scl_lo = 1'b0;
                        if (!scl_h) begin
                            n.ovf_cnt = 2'h0;
                        end else if (q.ovf_cnt != 2'h0) begin
                            // flag cleared as stop goes out
                            // start follows via idle if requested
                            n.halt_condition_flag = 1'b0;
                            n.master = 1'b0;
                            n.transmitter_flag = 1'b0;
                            n.framed = 1'b0;
                            n.st = ST_IDLE;
                        end
                    end
                end
                ST_RSTART: begin
                    if (q.hold_cnt == 4'h0 && !q.sda_lo && q.setup_cnt == 4'h0) begin
                        n.scl_lo = 1'b0;
                    end
                    if (scl_h && !q.scl_lo) begin
                        n.st = ST_START;
                        n.master = 1'b0;
                        n.ovf_cnt = 2'h0;
                    end
                end
                default: begin
                    n.st = ST_IDLE;
                end
            endcase

            // ---------------------------------------------------------------
            // data line drive with hold and setup timing
            // ---------------------------------------------------------------
            if (q.st == ST_START || q.st == ST_STOP) begin
                want = 1'b1;
            end else if (q.st == ST_RSTART) begin
                want = 1'b0;
            end else if (active && q.bitcnt == `ACK_SLOT) begin
                // ack level appears right after write
                want = ~q.transmitter_flag & q.ack;
            end else if (active && q.transmitter_flag) begin
                want = ~q.dat[7];
            end
            if (q.hold_cnt == 4'h0 && want != q.sda_lo) begin
                n.sda_lo = want;
                n.setup_cnt = q.lsh ? `SETUP_EXT : `SETUP_NORM;
            end
        end else begin
            n.st = ST_IDLE;
            n.master = 1'b0;
            n.slv = 1'b0;
            n.transmitter_flag = 1'b0;
            n.busy = 1'b0;
            n.scl_lo = 1'b0;
            n.sda_lo = 1'b0;
            n.bitcnt = 4'h0;
            n.framed = 1'b0;
            n.free_cnt = 4'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    rx_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(q.rx_push),
        .in_ready(fifo_in_ready),
        .in_data(q.rx_byte),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // open drain: only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = q.scl_lo;
    assign sda_oe = q.sda_lo;
    assign sfr_rdata = q.rdata;
    assign t3_reload_lo = q.t3_rl_lo;
    assign t3_reload_hi = q.t3_rl_hi;
endmodule

// *** rtl/smbus_defines.svh ***
`ifndef SMBUS_DEFINES_SVH
`define SMBUS_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------------------
`define CTRL_ADDR 8'hC0
`define CFG_ADDR 8'hC1
`define DATA_ADDR 8'hC2
`define CTRL_RST 8'h00
`define CFG_RST 8'h00
`define DATA_RST 8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CFG_ON 7
`define CFG_INH 6
`define CFG_LSH 4
`define CFG_TOE 3
`define CFG_FTE 2
`define CFG_CS_HI 1
`define CFG_CS_LO 0
`define CTRL_STA 5
`define CTRL_STO 4
`define CTRL_ACK 1
`define CTRL_SI 0

// ----------------------------------------------------------------------------
// timing counts in system clocks or source overflows, bit slots and buffer size
// ----------------------------------------------------------------------------
`define HOLD_NORM 4'h3
`define HOLD_EXT 4'hC
`define SETUP_NORM 4'h1
`define SETUP_EXT 4'hB
`define FREE_PERIODS 4'hA
`define HIGH_OVF 2'h2
`define ACK_SLOT 4'h8
`define LAST_BIT 4'h7
`define FIFO_WIDTH 8
`define FIFO_DEPTH 32

`endif

// *** rtl/smbus_pkg.sv ***
package smbus_pkg;

    // gray order along idle -> start -> low -> high, stop and restart off it
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_LOW = 3'h3,
        ST_HIGH = 3'h2,
        ST_STOP = 3'h6,
        ST_RSTART = 3'h7
    } phase_t;

    typedef struct packed {
        phase_t st;
        logic on;
        logic slave_silence;
        logic lsh;
        logic toe;
        logic fte;
        logic [1:0] cs;
        logic master;
        logic transmitter_flag;
        logic begin_condition_flag;
        logic halt_condition_flag;
        logic response_needed;
        logic arbitration_lost_flag;
        logic ack;
        logic si;
        logic busy;
        logic [7:0] dat;
        logic dat_wr;
        logic [3:0] bitcnt;
        logic slv;
        logic addr_ph;
        logic ignore;
        logic inh_eff;
        logic framed;
        logic [3:0] free_cnt;
        logic [1:0] ovf_cnt;
        logic [3:0] hold_cnt;
        logic [3:0] setup_cnt;
        logic scl_lo;
        logic sda_lo;
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [7:0] rdata;
        logic t3_rl_lo;
        logic t3_rl_hi;
        logic [7:0] rx_byte;
        logic rx_push;
    } ctl_t;

endpackage

// *** bench/smbus_master_slave_control_monitor.sv ***
`timescale 1ns/1ns
module smbus_master_slave_control_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic timer3_split_mode,
    input wire logic t3_reload_lo,
    input wire logic t3_reload_hi
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic cfg_wr = sfr_wr && sfr_addr == 8'hC1;
    wire logic ctl_wr = sfr_wr && sfr_addr == 8'hC0;
    // ----
    // checks
    // ----
    chk_open_drain: assert property (scl_out == 1'h0)
        else $error("clock line driven high");
    chk_reload_off: assert property (cfg_wr && !sfr_wdata[3] |-> ##2 !t3_reload_hi)
        else $error("reload held with low timeout off");
    chk_split_reload: assert property (timer3_split_mode [*3] |-> !t3_reload_lo)
        else $error("low byte reloaded in split mode");
    chk_low_reload: assert property (!scl_in [*5] |-> !t3_reload_hi)
        else $error("timer held in reload while clock low");
    chk_read_hold: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property
        (sfr_rd && !(sfr_addr inside {[8'hC0:8'hC2]}) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_cfg_readback: assert property
        (cfg_wr ##2 (sfr_rd && sfr_addr == 8'hC1 && !sfr_wr)
        |=> (sfr_rdata & 8'hDF) == ($past(sfr_wdata, 3) & 8'hDF))
        else $error("config readback differs");
    chk_disable_release: assert property (cfg_wr && !sfr_wdata[7] |-> ##2 !(scl_oe || sda_oe))
        else $error("lines held while disabled");
    chk_arb_clear: assert property
        (ctl_wr && !sfr_wdata[0] ##2 (sfr_rd && sfr_addr == 8'hC0 && !sfr_wr)
        |=> !sfr_rdata[2] && !sfr_rdata[0])
        else $error("flags survive event clear");
endmodule

// *** bench/bus_peer.sv ***
`timescale 1ns/1ns
module bus_peer (
    output logic scl_pull,
    output logic sda_pull
);
    initial begin
        scl_pull = 1'h0;
        sda_pull = 1'h0;
    end
    // ----
    // open-drain traffic, 80 ns link clock
    // ----
    // peer opens transfer
    task automatic start_c();
        #40 sda_pull = 1'h1;
        #40 scl_pull = 1'h1;
    endtask
    // both lines end high without a stop
    task automatic bit_c();
        #40 sda_pull = 1'h0;
        #40 scl_pull = 1'h0;
    endtask
    // byte msb first, ends with clock low
    task automatic byte_c(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #20 sda_pull = !b[i];
            #20 scl_pull = 1'h0;
            #40 scl_pull = 1'h1;
        end
    endtask
    task automatic hold_low(input int ns);
        scl_pull = 1'h1;
        #(ns) scl_pull = 1'h0;
    endtask
endmodule

// *** bench/smbus_master_slave_control_tb.sv ***
`timescale 1ns/1ns
module smbus_master_slave_control_tb;
    logic ref_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, split = 0, rx_ready = 1, ovf = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rx_data;
    logic scl_oe, sda_oe, scl_out, sda_out, r_lo, r_hi, rx_valid, p_scl, p_sda;
    wire logic scl = !(scl_oe | p_scl);
    wire logic sda = !(sda_oe | p_sda);
    int mismatches = 0, tests_run = 0, cyc = 0;
    smbus_master_slave_control dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .scl_in(scl),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .t0_ovf(ovf), .t1_ovf(ovf), .t2h_ovf(ovf), .t2l_ovf(ovf),
        .timer3_split_mode(split), .t3_reload_lo(r_lo), .t3_reload_hi(r_hi),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));
    bus_peer peer (.scl_pull(p_scl), .sda_pull(p_sda));
    // ----
    // clock, overflow source, hang guard
    // ----
    initial forever #5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        cyc <= cyc + 1;
        ovf <= (cyc % 16 == 0);
        if (cyc == 5000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        @(negedge ref_clk);
        sfr_wr = 0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1;
        @(negedge ref_clk);
        sfr_rd = 0;
        @(negedge ref_clk);
        chk("register", e, sfr_rdata & m);
    endtask
    task automatic t_cfg();
        wr(8'hC1, 8'hBF);
        rchk(8'hC1, 8'hFF, 8'h9F);
        chk("reload_lo", 1'h1, r_lo);
        split = 1;
        repeat (4) @(negedge ref_clk);
        chk("reload_lo", 1'h0, r_lo);
        split = 0;
        fork
            peer.hold_low(300);
            begin
                repeat (8) @(negedge ref_clk);
                chk("reload_hi", 1'h0, r_hi);
            end
        join
        wr(8'hC1, 8'h00);
    endtask
    task automatic t_free();
        wr(8'hC1, 8'h84);
        peer.start_c();
        rchk(8'hC1, 8'h20, 8'h20);
        peer.bit_c();
        repeat (100) @(negedge ref_clk);
        rchk(8'hC1, 8'h20, 8'h20);
        repeat (150) @(negedge ref_clk);
        rchk(8'hC1, 8'h20, 8'h00);
        rchk(8'hC0, 8'h11, 8'h11);
        wr(8'hC0, 8'h00);
        rchk(8'hC0, 8'h05, 8'h00);
    endtask
    task automatic t_master();
        int n = 0;
        wr(8'hC0, 8'h20);
        while (scl_oe !== 1'h1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        chk("scl_oe", 1'h1, scl_oe);
        chk("sda_oe", 1'h1, sda_oe);
        rchk(8'hC0, 8'hFF, 8'hE1);
        repeat (50) @(negedge ref_clk);
        chk("scl_oe", 1'h1, scl_oe);
        wr(8'hC1, 8'h00);
        repeat (3) @(negedge ref_clk);
        chk("lines", 1'h0, scl_oe | sda_oe);
    endtask
    task automatic t_slave();
        wr(8'hC0, 8'h00);
        wr(8'hC1, 8'h80);
        rx_ready = 0;
        peer.start_c();
        peer.byte_c(8'hA5);
        repeat (8) @(negedge ref_clk);
        chk("rx_valid", 1'h1, rx_valid);
        chk("rx_data", 8'hA5, rx_data);
        chk("scl_oe", 1'h1, scl_oe);
        chk("pins out", 8'h00, {scl_out, sda_out});
        rchk(8'hC0, 8'hFF, 8'h29);
        rchk(8'hC2, 8'hFF, 8'hA5);
        wr(8'hC0, 8'h03);
        repeat (2) @(negedge ref_clk);
        chk("sda_oe", 1'h1, sda_oe);
        chk("scl_oe", 1'h1, scl_oe);
        rx_ready = 1;
        wr(8'hC1, 8'h00);
        peer.bit_c();
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1;
        rchk(8'hC0, 8'hFF, 8'h00);
        rchk(8'hC1, 8'hFF, 8'h00);
        rchk(8'h55, 8'hFF, 8'h00);
        t_cfg();
        t_free();
        t_master();
        t_slave();
        test_done();
    end
endmodule
bind smbus_master_slave_control smbus_master_slave_control_monitor mon (
    .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .timer3_split_mode(timer3_split_mode), .t3_reload_lo(t3_reload_lo),
    .t3_reload_hi(t3_reload_hi));
